// file: ufc_pkg.sv
package ufc_pkg;
    localparam int unsigned ADR_W = 5;
    localparam int unsigned DAT_W = 32;
    localparam int unsigned LVL_W = 7;
    // Register byte addresses
    localparam logic [4:0] ADDR_FIFO_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_ENH_FEATURE = 5'h04;
    localparam logic [4:0] ADDR_STATUS = 5'h08;
    localparam logic [4:0] ADDR_TX_DATA = 5'h0c;
    localparam logic [4:0] ADDR_RX_DATA = 5'h10;
    // fifo_control fields
    localparam int unsigned FC_RX_TRIG_LSB = 6;
    localparam int unsigned FC_TX_TRIG_LSB = 4;
    localparam int unsigned FC_DMA_BIT = 3;
    localparam int unsigned FC_TX_FLUSH_BIT = 2;
    localparam int unsigned FC_RX_FLUSH_BIT = 1;
    localparam int unsigned FC_EN_BIT = 0;
    // enhanced_feature_register field
    localparam int unsigned EFR_ENH_BIT = 4;
    // Status register fields
    localparam int unsigned ST_RX_CNT_LSB = 0;
    localparam int unsigned ST_TX_CNT_LSB = 8;
    localparam int unsigned ST_RX_TRIG_BIT = 16;
    localparam int unsigned ST_TX_TRIG_BIT = 17;
    localparam int unsigned ST_EN_BIT = 18;
    localparam int unsigned ST_DMA_BIT = 19;
    localparam int unsigned ST_ENH_BIT = 20;
    // Trigger levels per code
    localparam logic [6:0] RX_LVL_0 = 7'h08;
    localparam logic [6:0] RX_LVL_1 = 7'h10;
    localparam logic [6:0] RX_LVL_2 = 7'h38;
    localparam logic [6:0] RX_LVL_3 = 7'h3c;
    localparam logic [6:0] TX_LVL_0 = 7'h08;
    localparam logic [6:0] TX_LVL_1 = 7'h10;
    localparam logic [6:0] TX_LVL_2 = 7'h20;
    localparam logic [6:0] TX_LVL_3 = 7'h38;

    typedef struct packed {
        logic [1:0] rx_trig;
        logic [1:0] tx_trig;
        logic dma_mode;
        logic fifo_en;
    } ufc_ctrl_s;

    localparam ufc_ctrl_s CTRL_RESET = '{rx_trig: 2'h0, tx_trig: 2'h0, dma_mode: 1'b0, fifo_en: 1'b0};

    function automatic logic [6:0] rx_level(input logic [1:0] code);
        case (code)
            2'h0: rx_level = RX_LVL_0;
            2'h1: rx_level = RX_LVL_1;
            2'h2: rx_level = RX_LVL_2;
            default: rx_level = RX_LVL_3;
        endcase
    endfunction

    function automatic logic [6:0] tx_level(input logic [1:0] code);
        case (code)
            2'h0: tx_level = TX_LVL_0;
            2'h1: tx_level = TX_LVL_1;
            2'h2: tx_level = TX_LVL_2;
            default: tx_level = TX_LVL_3;
        endcase
    endfunction
endpackage

// file: ufc_shift_model.sv
module ufc_shift_model (
    input wire logic clk_i, // Clock
    input wire logic stall_i, // Hold off the transmit stage
    input wire logic tx_valid_i, // Byte offered
    input wire logic [7:0] tx_data_i, // Offered byte
    output logic tx_ready_o, // Transmit stage takes byte
    output logic rx_valid_o, // Byte presented
    output logic [7:0] rx_data_o, // Presented byte
    input wire logic rx_ready_i // Receive FIFO takes byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pend[$];
    logic [7:0] got[$];
    initial tx_ready_o = 1'b0;
    initial rx_valid_o = 1'b0;
    initial rx_data_o = 8'h5a;
    task automatic send(input logic [7:0] b);
        pend.push_back(b);
    endtask
    always @(posedge clk_i) begin
        tx_ready_o <= ~stall_i;
        if (tx_valid_i && tx_ready_o) begin
            got.push_back(tx_data_i);
        end
        if (!rx_valid_o || rx_ready_i) begin
            if (pend.size() != 0) begin
                rx_valid_o <= 1'b1;
                rx_data_o <= pend.pop_front();
            end else begin
                // Idle data toggles so a stale byte is never mistaken for a new one
                rx_valid_o <= 1'b0;
                rx_data_o <= ~rx_data_o;
            end
        end
    end
endmodule // ufc_shift_model

// file: ufc_uart_fifo_control.sv
// Summary of operation
// - fifo_control is write-only; reading its address returns zero.
// - Bits 7:6 pick receive trigger: 8, 16, 56 or 60 characters.
// - Bits 5:4 pick transmit trigger: 8, 16, 32 or 56 free spaces.
// - Transmit trigger field changes and applies only with enhanced functions on.
// - Bit 3 selects DMA signalling mode 0 or 1.
// - Bit 2 empties transmit FIFO, leaves shift stage alone, self-clears.
// - Bit 1 empties receive FIFO, leaves shift stage alone, self-clears.
// - Bit 0 enables both FIFOs when 1, disables both when 0.
// - After reset FIFOs are disabled and no flush is pending.
// - With FIFOs off, receiver keeps one character in entry zero, overwriting.
// - Each FIFO holds 64 byte entries.
// - Enhanced bits change only while enhanced functions are enabled.
//
// Our own choices: the Wishbone slave port and the placing of the registers.
module ufc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 64,
    parameter int unsigned CW = $clog2(DEPTH + 1)
) (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Sync reset
    input wire logic flush_i, // Empty the FIFO
    input wire logic single_i, // One-entry mode at entry zero
    input wire logic overwrite_i, // Single mode replaces unread entry
    input wire logic in_valid_i, // Write request
    input wire logic [WIDTH-1:0] in_data_i, // Write data
    output logic in_ready_o, // Room available
    output logic out_valid_o, // Data available
    output logic [WIDTH-1:0] out_data_o, // Head entry
    input wire logic out_ready_i, // Pop
    output logic [CW-1:0] count_o // Fill level
);
    localparam int unsigned IW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [IW-1:0] wp;
        logic [IW-1:0] rp;
        logic [CW-1:0] cnt;
        logic rdy;
    } ufc_fifo_st_s;
    ufc_fifo_st_s q, d;
    logic push, pop, counted;

    // Nothing pops during a flush, so a doomed byte cannot slip into the stage
    assign out_valid_o = (q.cnt != '0) && !flush_i;
    assign out_data_o = q.mem[q.rp];
    assign in_ready_o = q.rdy;
    assign count_o = q.cnt;

    always_comb begin
        d = q;
        push = in_valid_i && q.rdy;
        pop = out_valid_o && out_ready_i;
        // A single-mode overwrite leaves the count at one
        counted = push && !(single_i && (q.cnt != '0) && !pop);
        if (pop && !single_i) begin
            d.rp = q.rp + 1'b1;
        end
        if (push) begin
            d.mem[q.wp] = in_data_i;
            if (!single_i) begin
                d.wp = q.wp + 1'b1;
            end
        end
        d.cnt = q.cnt + CW'(counted) - CW'(pop);
        // Storage is left as is; only pointers and count go back
        if (flush_i) begin
            d.wp = '0;
            d.rp = '0;
            d.cnt = '0;
        end
        // A disabled receiver always accepts: the newest byte replaces entry zero
        if (single_i && overwrite_i) begin
            d.rdy = 1'b1;
        end else if (single_i) begin
            d.rdy = (d.cnt == '0);
        end else begin
            d.rdy = (d.cnt < CW'(DEPTH));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule // ufc_fifo

module ufc_uart_fifo_control #(
    parameter int unsigned DEPTH = 64,
    parameter int unsigned CW = $clog2(DEPTH + 1)
) (
    input wire logic clk_i, // 40 MHz clock
    input wire logic rst_i, // Sync reset, active high
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write
    input wire logic [4:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte enables
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    output logic tx_valid_o, // Byte for transmit shift stage
    output logic [7:0] tx_data_o, // Transmit byte
    input wire logic tx_ready_i, // Shift stage takes byte
    input wire logic rx_valid_i, // Byte from receive shift stage
    input wire logic [7:0] rx_data_i, // Received byte
    output logic rx_ready_o, // Receive FIFO accepts
    output logic fifo_en_o, // FIFOs enabled
    output logic dma_mode_o, // DMA signalling mode
    output logic rx_trig_o, // Receive fill at level
    output logic tx_trig_o // Transmit space at level
);
    typedef struct packed {
        ufc_pkg::ufc_ctrl_s ctrl;
        logic enh;
        logic flush_tx;
        logic flush_rx;
        logic ack;
        logic [31:0] dat;
        logic txv;
        logic [7:0] txd;
        logic rxt;
        logic txt;
    } ufc_top_st_s;
    ufc_top_st_s q, d;
    logic acc, wr, rd, fc_wr, en_change;
    logic [7:0] wb_byte;
    logic txf_in_valid, txf_in_ready, txf_out_valid, txf_out_ready;
    logic rxf_out_valid, rxf_out_ready;
    logic [7:0] txf_out_data, rxf_out_data;
    logic [CW-1:0] tx_cnt, rx_cnt;

    // The ack flop gates acc, so a held strobe is taken again only after ack falls
    assign acc = wb_cyc_i && wb_stb_i && !q.ack;
    assign wr = acc && wb_we_i && wb_sel_i[0];
    assign rd = acc && !wb_we_i;
    assign wb_byte = wb_dat_i[7:0];
    assign fc_wr = wr && (wb_adr_i == ufc_pkg::ADDR_FIFO_CONTROL);
    assign en_change = wb_byte[ufc_pkg::FC_EN_BIT] != q.ctrl.fifo_en;
    // Host bytes are dropped when the transmit FIFO is full
    assign txf_in_valid = wr && (wb_adr_i == ufc_pkg::ADDR_TX_DATA);
    assign rxf_out_ready = rd && (wb_adr_i == ufc_pkg::ADDR_RX_DATA);
    assign txf_out_ready = !q.txv || tx_ready_i;

    ufc_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .flush_i(q.flush_tx),
        .single_i(!q.ctrl.fifo_en),
        .overwrite_i(1'b0),
        .in_valid_i(txf_in_valid),
        .in_data_i(wb_byte),
        .in_ready_o(txf_in_ready),
        .out_valid_o(txf_out_valid),
        .out_data_o(txf_out_data),
        .out_ready_i(txf_out_ready),
        .count_o(tx_cnt)
    );

    ufc_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .flush_i(q.flush_rx),
        .single_i(!q.ctrl.fifo_en),
        .overwrite_i(1'b1),
        .in_valid_i(rx_valid_i),
        .in_data_i(rx_data_i),
        .in_ready_o(rx_ready_o),
        .out_valid_o(rxf_out_valid),
        .out_data_o(rxf_out_data),
        .out_ready_i(rxf_out_ready),
        .count_o(rx_cnt)
    );

    always_comb begin
        d = q;
        d.ack = acc;
        d.flush_tx = 1'b0;
        d.flush_rx = 1'b0;
        if (fc_wr) begin
            d.ctrl.rx_trig = wb_byte[ufc_pkg::FC_RX_TRIG_LSB +: 2];
            if (q.enh) begin
                d.ctrl.tx_trig = wb_byte[ufc_pkg::FC_TX_TRIG_LSB +: 2];
            end
            d.ctrl.dma_mode = wb_byte[ufc_pkg::FC_DMA_BIT];
            d.ctrl.fifo_en = wb_byte[ufc_pkg::FC_EN_BIT];
            // Changing the enable empties both, so single mode starts at entry zero
            d.flush_tx = wb_byte[ufc_pkg::FC_TX_FLUSH_BIT] || en_change;
            d.flush_rx = wb_byte[ufc_pkg::FC_RX_FLUSH_BIT] || en_change;
        end
        if (wr && (wb_adr_i == ufc_pkg::ADDR_ENH_FEATURE)) begin
            d.enh = wb_byte[ufc_pkg::EFR_ENH_BIT];
        end
        if (rd) begin
            d.dat = '0;
            case (wb_adr_i)
                ufc_pkg::ADDR_ENH_FEATURE: d.dat[ufc_pkg::EFR_ENH_BIT] = q.enh;
                ufc_pkg::ADDR_STATUS: begin
                    d.dat[ufc_pkg::ST_RX_CNT_LSB +: CW] = rx_cnt;
                    d.dat[ufc_pkg::ST_TX_CNT_LSB +: CW] = tx_cnt;
                    d.dat[ufc_pkg::ST_RX_TRIG_BIT] = q.rxt;
                    d.dat[ufc_pkg::ST_TX_TRIG_BIT] = q.txt;
                    d.dat[ufc_pkg::ST_EN_BIT] = q.ctrl.fifo_en;
                    d.dat[ufc_pkg::ST_DMA_BIT] = q.ctrl.dma_mode;
                    d.dat[ufc_pkg::ST_ENH_BIT] = q.enh;
                end
                ufc_pkg::ADDR_RX_DATA: d.dat[7:0] = rxf_out_valid ? rxf_out_data : 8'h00;
                default: d.dat = '0;
            endcase
        end
        // Output stage stands for the shift register a flush must not touch
        if (txf_out_valid && txf_out_ready) begin
            d.txv = 1'b1;
            d.txd = txf_out_data;
        end else if (tx_ready_i) begin
            d.txv = 1'b0;
        end
        d.rxt = q.ctrl.fifo_en && (rx_cnt >= CW'(ufc_pkg::rx_level(q.ctrl.rx_trig)));
        d.txt = q.ctrl.fifo_en && ((CW'(DEPTH) - tx_cnt) >=
            CW'(ufc_pkg::tx_level(q.enh ? q.ctrl.tx_trig : 2'h0)));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.ctrl <= ufc_pkg::CTRL_RESET;
        end else begin
            q <= d;
        end
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;
    assign tx_valid_o = q.txv;
    assign tx_data_o = q.txd;
    assign fifo_en_o = q.ctrl.fifo_en;
    assign dma_mode_o = q.ctrl.dma_mode;
    assign rx_trig_o = q.rxt;
    assign tx_trig_o = q.txt;

    // Flags lag the counts by one cycle, so checks compare against the past cycle
    AST_FC_READS_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        rd && (wb_adr_i == ufc_pkg::ADDR_FIFO_CONTROL) |=> wb_ack_o && (wb_dat_o == 32'h0))
        else $error("fifo_control read returned data");
    AST_RX_TRIG: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 rx_trig_o == $past(fifo_en_o && (rx_cnt >= CW'(ufc_pkg::rx_level(q.ctrl.rx_trig)))))
        else $error("receive trigger flag wrong");
    AST_TX_TRIG: assert property (@(posedge clk_i) disable iff (rst_i)
        fifo_en_o && q.enh && (tx_cnt == '0) && $stable(q.ctrl) |=> tx_trig_o)
        else $error("transmit trigger flag missing");
    AST_TX_FIELD_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
        fc_wr && !q.enh |=> $stable(q.ctrl.tx_trig))
        else $error("transmit trigger field changed while locked");
    AST_DMA_MODE: assert property (@(posedge clk_i) disable iff (rst_i)
        fc_wr |=> dma_mode_o == $past(wb_dat_i[ufc_pkg::FC_DMA_BIT]))
        else $error("DMA mode not taken");
    AST_TX_FLUSH: assert property (@(posedge clk_i) disable iff (rst_i)
        fc_wr && wb_dat_i[ufc_pkg::FC_TX_FLUSH_BIT] |=> q.flush_tx ##1 (!q.flush_tx && tx_cnt == '0))
        else $error("transmit flush did not empty FIFO");
    AST_RX_FLUSH: assert property (@(posedge clk_i) disable iff (rst_i)
        fc_wr && wb_dat_i[ufc_pkg::FC_RX_FLUSH_BIT] |-> ##2 (rx_cnt == '0) && !q.flush_rx)
        else $error("receive flush did not empty FIFO");
    AST_ENABLE: assert property (@(posedge clk_i) disable iff (rst_i)
        fc_wr |=> fifo_en_o == $past(wb_dat_i[ufc_pkg::FC_EN_BIT]))
        else $error("enable not taken");
    AST_RESET_STATE: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> !fifo_en_o && !q.flush_tx && !q.flush_rx)
        else $error("state after reset wrong");
    AST_SINGLE_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
        !fifo_en_o && $past(!fifo_en_o) && !$past(rst_i) |-> (rx_cnt <= CW'(1)) && rx_ready_o)
        else $error("disabled receiver holds more than one entry");
    AST_DEPTH: assert property (@(posedge clk_i) disable iff (rst_i)
        (rx_cnt <= CW'(DEPTH)) && (tx_cnt <= CW'(DEPTH)))
        else $error("FIFO count beyond depth");
    AST_RX_FULL: assert property (@(posedge clk_i) disable iff (rst_i)
        fifo_en_o && (rx_cnt == CW'(DEPTH)) |-> !rx_ready_o)
        else $error("full receive FIFO still ready");
    AST_RX_TRIG_FULL: assert property (@(posedge clk_i) disable iff (rst_i)
        fifo_en_o && (rx_cnt == CW'(DEPTH)) |=> rx_trig_o)
        else $error("full receive FIFO without trigger");
    AST_TX_TRIG_FULL: assert property (@(posedge clk_i) disable iff (rst_i)
        fifo_en_o && (tx_cnt == CW'(DEPTH)) |=> !tx_trig_o)
        else $error("transmit trigger with no free space");
    AST_FLUSH_SELF_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        q.flush_tx || q.flush_rx |=> !q.flush_tx && !q.flush_rx)
        else $error("flush request did not clear itself");
    AST_STAGE_KEPT: assert property (@(posedge clk_i) disable iff (rst_i)
        q.flush_tx && tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("transmit flush disturbed the shift stage");
    AST_SEL_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && !wb_sel_i[0] &&
        (wb_adr_i == ufc_pkg::ADDR_FIFO_CONTROL) |=> $stable(q.ctrl))
        else $error("write without byte lane zero changed control");
    // Main scenarios
    COV_STAGE_TAKE: cover property (@(posedge clk_i) disable iff (rst_i) tx_valid_o && tx_ready_i);
    COV_TX_FLUSH: cover property (@(posedge clk_i) disable iff (rst_i)
        (tx_cnt != '0) ##1 q.flush_tx ##1 (tx_cnt == '0));
    COV_RX_TRIG: cover property (@(posedge clk_i) disable iff (rst_i) $rose(rx_trig_o));
    COV_RX_FULL: cover property (@(posedge clk_i) disable iff (rst_i) fifo_en_o && !rx_ready_o);
    COV_OVERWRITE: cover property (@(posedge clk_i) disable iff (rst_i)
        !fifo_en_o && rx_valid_i && (rx_cnt == CW'(1)));
endmodule // ufc_uart_fifo_control

// file: ufc_uart_fifo_control_bench.sv
module ufc_uart_fifo_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, stall = 1'b1;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'h0, wsel = 4'hf;
    logic [31:0] wdat = 32'h0, q, rnd = 32'h7121;
    logic [31:0] rdat;
    logic ack, txv, txr, rxv, rxr, fen, dma, rxt, txt;
    logic [7:0] txd, rxd;
    int err_total = 0, checks = 0, cyc_n = 0, n;
    int rxl[4] = '{8, 16, 56, 60};
    int txl[4] = '{8, 16, 32, 56};
    logic [7:0] rxq[$], txq[$], stage_b, a;
    bit stage = 0, enh = 0, en = 0, dma_m = 0;
    logic [1:0] c, rcode = 2'h0, tcode = 2'h0;

    ufc_uart_fifo_control dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .tx_valid_o(txv), .tx_data_o(txd), .tx_ready_i(txr), .rx_valid_i(rxv),
        .rx_data_i(rxd), .rx_ready_o(rxr), .fifo_en_o(fen), .dma_mode_o(dma), .rx_trig_o(rxt),
        .tx_trig_o(txt));
    ufc_shift_model m (.clk_i(clk_i), .stall_i(stall), .tx_valid_i(txv), .tx_data_i(txd),
        .tx_ready_o(txr), .rx_valid_o(rxv), .rx_data_o(rxd), .rx_ready_i(rxr));

    always #12.5 clk_i = ~clk_i;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected status word from the queue model; disabled enhanced mode falls back to 8 spaces
    function automatic logic [31:0] exp_st();
        int rc = rxq.size();
        int tc = txq.size();
        int tl = enh ? txl[tcode] : txl[0];
        return {11'h0, enh, dma_m, en, en && (64 - tc) >= tl, en && rc >= rxl[rcode],
            1'b0, tc[6:0], 1'b0, rc[6:0]};
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic wb(input logic w, input logic [4:0] ad, input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= d;
        sel <= wsel;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (k >= 50) begin
            err_total++;
            end_of_test();
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1 cmp({fen, dma, rxt, txt, txv}, 32'h0);
        wb(0, 5'h14, 32'h0, q);
        cmp(q, 32'h0);
        for (int k = 0; k < 8; k++) begin
            enh = (k < 4);
            wb(1, ufc_pkg::ADDR_ENH_FEATURE, {27'h0, enh, 4'h0}, q);
            c = k[1:0];
            dma_m = k[0];
            en = 1;
            rcode = c;
            if (enh) tcode = c;
            wb(1, ufc_pkg::ADDR_FIFO_CONTROL, {24'h0, c, c, dma_m, 3'b111}, q);
            rxq.delete();
            txq.delete();
            wb(0, ufc_pkg::ADDR_STATUS, 32'h0, q);
            cmp(q, exp_st());
            cmp({dma, fen}, {dma_m, 1'b1});
            wb(0, ufc_pkg::ADDR_FIFO_CONTROL, 32'h0, q);
            cmp(q, 32'h0);
            for (int i = 1; i <= 65; i++) begin
                rnd = lfsr(rnd);
                if (i <= 64) begin
                    m.send(rnd[7:0]);
                    rxq.push_back(rnd[7:0]);
                end
                wb(1, ufc_pkg::ADDR_TX_DATA, {24'h0, rnd[15:8]}, q);
                // The first byte ever pushed parks in the stalled shift stage
                if (!stage) begin
                    stage = 1;
                    stage_b = rnd[15:8];
                end else if (txq.size() < 64) txq.push_back(rnd[15:8]);
                wb(0, ufc_pkg::ADDR_STATUS, 32'h0, q);
                cmp(q, exp_st());
            end
        end
        foreach (rxq[j]) begin
            wb(0, ufc_pkg::ADDR_RX_DATA, 32'h0, q);
            cmp(q, {24'h0, rxq[j]});
        end
        wb(0, ufc_pkg::ADDR_RX_DATA, 32'h0, q);
        cmp(q, 32'h0);
        stall <= 1'b0;
        n = 0;
        while (m.got.size() < 65 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        cmp(m.got.size(), 65);
        cmp(m.got[0], stage_b);
        foreach (txq[j]) cmp(m.got[j + 1], txq[j]);
        en = 0;
        wb(1, ufc_pkg::ADDR_FIFO_CONTROL, 32'h0, q);
        cmp(fen, 1'b0);
        rnd = lfsr(rnd);
        a = rnd[7:0];
        m.send(a);
        m.send(~a);
        wb(0, ufc_pkg::ADDR_STATUS, 32'h0, q);
        wb(0, ufc_pkg::ADDR_RX_DATA, 32'h0, q);
        cmp(q, {24'h0, ~a});
        wsel = 4'he;
        wb(1, ufc_pkg::ADDR_FIFO_CONTROL, 32'h1, q);
        wsel = 4'hf;
        cmp(fen, 1'b0);
        end_of_test();
    end
endmodule // ufc_uart_fifo_control_bench
